/* profile_regs_pkg.sv */
// Package with the map, field layout and carrier types of the reference profile bank.
`default_nettype none
package profile_regs_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address on the bus is four times the index)
	// ----------------------------------------------------------------
	localparam logic [13:0] IDX_FIRST       = 14'h0633;
	localparam logic [13:0] IDX_LAST        = 14'h067F;
	localparam int          BANK_BYTES      = 77;
	localparam logic [13:0] IDX_REF_PERIOD  = 14'h0633;
	localparam logic [13:0] IDX_PERIOD_PAD  = 14'h0638;
	localparam logic [13:0] IDX_INNER_TOL   = 14'h063A;
	localparam logic [13:0] IDX_OUTER_TOL   = 14'h063D;
	localparam logic [13:0] IDX_VALID_MS    = 14'h0640;
	localparam logic [13:0] IDX_REDETECT_MS = 14'h0642;
	localparam logic [13:0] IDX_COEF1_LIN   = 14'h0644;
	localparam logic [13:0] IDX_COEF1_EXP   = 14'h0646;
	localparam logic [13:0] IDX_COEF2_LO    = 14'h0647;
	localparam logic [13:0] IDX_COEF2_MID   = 14'h0648;
	localparam logic [13:0] IDX_COEF2_HI    = 14'h0649;
	localparam logic [13:0] IDX_COEF3_LIN   = 14'h064A;
	localparam logic [13:0] IDX_COEF3_HI    = 14'h064C;
	localparam logic [13:0] IDX_COEF4_LO    = 14'h064D;
	localparam logic [13:0] IDX_COEF4_MIX   = 14'h064E;
	localparam logic [13:0] IDX_EXP_PACK    = 14'h064F;
	localparam logic [13:0] IDX_IN_DIV      = 14'h0650;
	localparam logic [13:0] IDX_IN_DIV_TOP  = 14'h0653;
	localparam logic [13:0] IDX_FB_DIV      = 14'h0654;
	localparam logic [13:0] IDX_FB_DIV_TOP  = 14'h0656;
	localparam logic [13:0] IDX_FB_PAD      = 14'h0657;
	localparam logic [13:0] IDX_FRAC_LO     = 14'h0658;
	localparam logic [13:0] IDX_FRAC_MIX    = 14'h0659;
	localparam logic [13:0] IDX_FRAC_HI     = 14'h065A;
	localparam logic [13:0] IDX_PHASE_THR   = 14'h065B;
	localparam logic [13:0] IDX_PHASE_FILL  = 14'h065D;
	localparam logic [13:0] IDX_PHASE_DRAIN = 14'h065E;
	localparam logic [13:0] IDX_FREQ_THR    = 14'h065F;
	localparam logic [13:0] IDX_FREQ_FILL   = 14'h0662;
	localparam logic [13:0] IDX_FREQ_DRAIN  = 14'h0663;
	localparam logic [13:0] IDX_TAIL        = 14'h0664;

	// ----------------------------------------------------------------
	// Writable-bit masks, reset value and arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [7:0]  MASK_FULL       = 8'hFF;
	localparam logic [7:0]  MASK_NONE       = 8'h00;
	localparam logic [7:0]  MASK_LOW_NIBBLE = 8'h0F;
	localparam logic [7:0]  MASK_LOW_SIX    = 8'h3F;
	localparam logic [7:0]  MASK_LOW_SEVEN  = 8'h7F;
	localparam logic [7:0]  MASK_FRAC_MIX   = 8'hF3;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [19:0] FB_DIV_MIN      = 20'h00007;
	localparam logic [9:0]  PS_PER_NS       = 10'h3E8;

	// Bits that hold no field are not stored, so they read back as zero.
	function automatic logic [7:0] byte_mask(input logic [13:0] idx);
		logic [7:0] m;
		m = MASK_FULL;
		case (idx)
			IDX_PERIOD_PAD, IDX_PERIOD_PAD + 14'h0001, IDX_FB_PAD: m = MASK_NONE;
			IDX_INNER_TOL + 14'h0002, IDX_OUTER_TOL + 14'h0002, IDX_FB_DIV_TOP: m = MASK_LOW_NIBBLE;
			IDX_COEF2_HI:                                       m = MASK_LOW_SEVEN;
			IDX_COEF3_HI, IDX_IN_DIV_TOP, IDX_FRAC_HI:          m = MASK_LOW_SIX;
			IDX_FRAC_MIX:                                       m = MASK_FRAC_MIX;
			default:                                            m = (idx >= IDX_TAIL) ? MASK_NONE : MASK_FULL;
		endcase
		return m;
	endfunction : byte_mask

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [15:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic [39:0] ref_period_fs;
		logic [19:0] inner_tol;
		logic [19:0] outer_tol;
		logic [15:0] validation_ms;
		logic [15:0] redetect_ms;
		logic [15:0] coef1_lin;
		logic [5:0]  coef1_exp_a;
		logic [2:0]  coef1_exp_b;
		logic [3:0]  coef1_exp_c;
		logic [16:0] coef2_lin;
		logic [4:0]  coef2_exp;
		logic [16:0] coef3_lin;
		logic [4:0]  coef3_exp;
		logic [14:0] coef4_lin;
		logic [4:0]  coef4_exp;
		logic [29:0] in_div;
		logic [19:0] fb_div;
		logic [9:0]  frac_numer;
		logic [9:0]  frac_modulus;
		logic [15:0] phase_thr;
		logic [7:0]  phase_fill;
		logic [7:0]  phase_drain;
		logic [23:0] freq_thr_ps;
		logic [7:0]  freq_fill;
		logic [7:0]  freq_drain;
	} loop_cfg_t;

endpackage : profile_regs_pkg
`default_nettype wire

/* wb_byte_slave.sv */
// Classic Wishbone slave front end that turns bus cycles into byte accesses.
`timescale 1ns/100ps
`default_nettype none
module wb_byte_slave
(
	input  wire logic                        sys_clk_in,
	input  wire logic                        rstn_in,
	input  wire profile_regs_pkg::wb_req_t   wb_req_in,
	input  wire logic [7:0]                  rd_byte_in,
	output var  profile_regs_pkg::wb_rsp_t   wb_rsp_out,
	output logic [13:0]                      idx_out,
	output logic                             hit_out,
	output logic                             wr_en_out
);

	logic        ack_r;
	logic [31:0] dat_r;
	logic        req_live;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// The word address is the register index; only the low lane carries data.
	assign idx_out  = wb_req_in.adr[15:2];
	assign hit_out  = (idx_out >= profile_regs_pkg::IDX_FIRST) &&
	                  (idx_out <= profile_regs_pkg::IDX_LAST);
	assign req_live = wb_req_in.cyc & wb_req_in.stb;

	// The write lands at the edge where the master sees ack, never earlier.
	assign wr_en_out = req_live & ack_r & wb_req_in.we & wb_req_in.sel[0] & hit_out;

	// ----------------------------------------------------------------
	// Answer
	// ----------------------------------------------------------------
	// Ack one cycle after the request and drop it right after, so a held request
	// is answered again every second cycle, never on two edges in a row.
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			ack_r <= 1'b0;
		else
			ack_r <= req_live & ~ack_r;
	end

	// Unmapped indices are acked with zero so software never hangs.
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			dat_r <= 32'h00000000;
		else if (req_live & ~ack_r)
			dat_r <= {24'h000000, (hit_out ? rd_byte_in : 8'h00)};
	end

	// One assignment drives the whole answer, so the struct has a single driver.
	assign wb_rsp_out = '{ack: ack_r, dat: dat_r};

endmodule : wb_byte_slave
`default_nettype wire

/* loop_ratio_unit.sv */
// Derived divide ratios and the scaled phase lock threshold for the loop logic.
`timescale 1ns/100ps
`default_nettype none
module loop_ratio_unit
(
	input  wire logic                        sys_clk_in,
	input  wire logic                        rstn_in,
	input  wire profile_regs_pkg::loop_cfg_t cfg_in,
	input  wire logic                        phase_scale_ns_in,
	output logic [30:0]                      in_div_ratio_out,
	output logic [20:0]                      fb_div_ratio_out,
	output logic                             fb_div_low_out,
	output logic [25:0]                      phase_thr_ps_out
);

	logic [25:0] thr_scaled;

	// Nanosecond scale is turned into picoseconds so the detector sees one unit.
	assign thr_scaled = 26'(cfg_in.phase_thr) * 26'(profile_regs_pkg::PS_PER_NS);

	// ----------------------------------------------------------------
	// Registered ratios
	// ----------------------------------------------------------------
	// Hardware divides by programmed value plus one.
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			in_div_ratio_out <= 31'h00000001;
			fb_div_ratio_out <= 21'h000001;
		end
		else
		begin
			in_div_ratio_out <= {1'b0, cfg_in.in_div} + 31'h00000001;
			fb_div_ratio_out <= {1'b0, cfg_in.fb_div} + 21'h000001;
		end
	end

	// Software must keep the feedback value at seven or more; flag a breach.
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			fb_div_low_out <= 1'b1;
		else
			fb_div_low_out <= (cfg_in.fb_div < profile_regs_pkg::FB_DIV_MIN);
	end

	// Clear scale bit means picoseconds, set means nanoseconds.
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			phase_thr_ps_out <= 26'h0000000;
		else
			phase_thr_ps_out <= phase_scale_ns_in ? thr_scaled : 26'(cfg_in.phase_thr);
	end

endmodule : loop_ratio_unit
`default_nettype wire

/* dpll_reference_profile_one_regs.sv */
// Register bank of one reference profile and assembly of its loop settings.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module dpll_reference_profile_one_regs
(
	input  wire logic                        sys_clk_in,
	input  wire logic                        rstn_in,
	input  wire profile_regs_pkg::wb_req_t   wb_req_in,
	output var  profile_regs_pkg::wb_rsp_t   wb_rsp_out,
	input  wire logic                        phase_scale_ns_in,
	input  wire logic                        profile_in_use_in,
	output var  profile_regs_pkg::loop_cfg_t loop_cfg_out,
	output logic                             cfg_apply_out,
	output logic [30:0]                      in_div_ratio_out,
	output logic [20:0]                      fb_div_ratio_out,
	output logic                             fb_div_low_out,
	output logic [25:0]                      phase_thr_ps_out
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]                  bank_r [0:profile_regs_pkg::BANK_BYTES-1];
	logic [13:0]                 idx;
	logic                        hit;
	logic                        wr_en;
	logic [13:0]                 rel_idx;
	logic [7:0]                  rd_byte;
	logic [7:0]                  wr_byte;
	profile_regs_pkg::loop_cfg_t cfg_nxt;
	profile_regs_pkg::loop_cfg_t cfg_r;
	logic                        apply_r;

	// ----------------------------------------------------------------
	// Bus front end
	// ----------------------------------------------------------------
	wb_byte_slave u_bus
	(
		.sys_clk_in (sys_clk_in),
		.rstn_in    (rstn_in),
		.wb_req_in  (wb_req_in),
		.rd_byte_in (rd_byte),
		.wb_rsp_out (wb_rsp_out),
		.idx_out    (idx),
		.hit_out    (hit),
		.wr_en_out  (wr_en)
	);

	assign rel_idx = idx - profile_regs_pkg::IDX_FIRST;
	assign wr_byte = wb_req_in.dat[7:0];

	// Reads index the bank only on a hit, so the subtraction cannot wrap into it.
	assign rd_byte = hit ? bank_r[rel_idx[6:0]] : 8'h00;

	// ----------------------------------------------------------------
	// Byte storage
	// ----------------------------------------------------------------
	// Each byte stores only its field bits; pads and tail keep nothing, which
	// also means a nonzero write to a pad simply vanishes.
	for (genvar g = 0; g < profile_regs_pkg::BANK_BYTES; g++)
	begin : g_byte
		localparam logic [13:0] BYTE_IDX  = profile_regs_pkg::IDX_FIRST + 14'(g);
		localparam logic [7:0]  BYTE_MASK = profile_regs_pkg::byte_mask(BYTE_IDX);

		always_ff @(posedge sys_clk_in or negedge rstn_in)
		begin
			if (!rstn_in)
				bank_r[g] <= profile_regs_pkg::RESET_BYTE;
			else if (wr_en && (idx == BYTE_IDX))
				bank_r[g] <= wr_byte & BYTE_MASK;
		end
	end

	// ----------------------------------------------------------------
	// Field assembly
	// ----------------------------------------------------------------
	// Gathers the scattered byte fields into whole values for the loop.
	// A function result cannot be bit-selected, so partial bytes index the array.
	function automatic logic [6:0] rel(input logic [13:0] i);
		return 7'(i - profile_regs_pkg::IDX_FIRST);
	endfunction : rel

	function automatic logic [7:0] at(input logic [13:0] i);
		return bank_r[rel(i)];
	endfunction : at

	always_comb
	begin
		cfg_nxt = '0;
		// Reference period and tolerances.
		cfg_nxt.ref_period_fs = {at(profile_regs_pkg::IDX_REF_PERIOD + 14'h0004),
		                         at(profile_regs_pkg::IDX_REF_PERIOD + 14'h0003),
		                         at(profile_regs_pkg::IDX_REF_PERIOD + 14'h0002),
		                         at(profile_regs_pkg::IDX_REF_PERIOD + 14'h0001),
		                         at(profile_regs_pkg::IDX_REF_PERIOD)};
		cfg_nxt.inner_tol = {bank_r[rel(profile_regs_pkg::IDX_INNER_TOL + 14'h0002)][3:0],
		                     at(profile_regs_pkg::IDX_INNER_TOL + 14'h0001),
		                     at(profile_regs_pkg::IDX_INNER_TOL)};
		cfg_nxt.outer_tol = {bank_r[rel(profile_regs_pkg::IDX_OUTER_TOL + 14'h0002)][3:0],
		                     at(profile_regs_pkg::IDX_OUTER_TOL + 14'h0001),
		                     at(profile_regs_pkg::IDX_OUTER_TOL)};
		// Timers.
		cfg_nxt.validation_ms = {at(profile_regs_pkg::IDX_VALID_MS + 14'h0001),
		                         at(profile_regs_pkg::IDX_VALID_MS)};
		cfg_nxt.redetect_ms   = {at(profile_regs_pkg::IDX_REDETECT_MS + 14'h0001),
		                         at(profile_regs_pkg::IDX_REDETECT_MS)};
		// Loop filter, each value a fraction and a power-of-two exponent.
		cfg_nxt.coef1_lin   = {at(profile_regs_pkg::IDX_COEF1_LIN + 14'h0001),
		                       at(profile_regs_pkg::IDX_COEF1_LIN)};
		cfg_nxt.coef1_exp_a = bank_r[rel(profile_regs_pkg::IDX_COEF1_EXP)][5:0];
		cfg_nxt.coef1_exp_b = {bank_r[rel(profile_regs_pkg::IDX_COEF2_LO)][0],
		                       bank_r[rel(profile_regs_pkg::IDX_COEF1_EXP)][7:6]};
		cfg_nxt.coef1_exp_c = bank_r[rel(profile_regs_pkg::IDX_EXP_PACK)][7:4];
		cfg_nxt.coef2_lin   = {bank_r[rel(profile_regs_pkg::IDX_COEF2_HI)][1:0],
		                       at(profile_regs_pkg::IDX_COEF2_MID),
		                       bank_r[rel(profile_regs_pkg::IDX_COEF2_LO)][7:1]};
		cfg_nxt.coef2_exp   = bank_r[rel(profile_regs_pkg::IDX_COEF2_HI)][6:2];
		cfg_nxt.coef3_lin   = {bank_r[rel(profile_regs_pkg::IDX_COEF3_HI)][0],
		                       at(profile_regs_pkg::IDX_COEF3_LIN + 14'h0001),
		                       at(profile_regs_pkg::IDX_COEF3_LIN)};
		cfg_nxt.coef3_exp   = bank_r[rel(profile_regs_pkg::IDX_COEF3_HI)][5:1];
		cfg_nxt.coef4_lin   = {bank_r[rel(profile_regs_pkg::IDX_COEF4_MIX)][6:0],
		                       at(profile_regs_pkg::IDX_COEF4_LO)};
		cfg_nxt.coef4_exp   = {bank_r[rel(profile_regs_pkg::IDX_EXP_PACK)][3:0],
		                       bank_r[rel(profile_regs_pkg::IDX_COEF4_MIX)][7]};
		// Dividers.
		cfg_nxt.in_div = {bank_r[rel(profile_regs_pkg::IDX_IN_DIV_TOP)][5:0],
		                  at(profile_regs_pkg::IDX_IN_DIV + 14'h0002),
		                  at(profile_regs_pkg::IDX_IN_DIV + 14'h0001),
		                  at(profile_regs_pkg::IDX_IN_DIV)};
		cfg_nxt.fb_div = {bank_r[rel(profile_regs_pkg::IDX_FB_DIV_TOP)][3:0],
		                  at(profile_regs_pkg::IDX_FB_DIV + 14'h0001),
		                  at(profile_regs_pkg::IDX_FB_DIV)};
		cfg_nxt.frac_numer   = {bank_r[rel(profile_regs_pkg::IDX_FRAC_MIX)][1:0],
		                        at(profile_regs_pkg::IDX_FRAC_LO)};
		cfg_nxt.frac_modulus = {bank_r[rel(profile_regs_pkg::IDX_FRAC_HI)][5:0],
		                        bank_r[rel(profile_regs_pkg::IDX_FRAC_MIX)][7:4]};
		// Lock detectors.
		cfg_nxt.phase_thr   = {at(profile_regs_pkg::IDX_PHASE_THR + 14'h0001),
		                       at(profile_regs_pkg::IDX_PHASE_THR)};
		cfg_nxt.phase_fill  = at(profile_regs_pkg::IDX_PHASE_FILL);
		cfg_nxt.phase_drain = at(profile_regs_pkg::IDX_PHASE_DRAIN);
		cfg_nxt.freq_thr_ps = {at(profile_regs_pkg::IDX_FREQ_THR + 14'h0002),
		                       at(profile_regs_pkg::IDX_FREQ_THR + 14'h0001),
		                       at(profile_regs_pkg::IDX_FREQ_THR)};
		cfg_nxt.freq_fill   = at(profile_regs_pkg::IDX_FREQ_FILL);
		cfg_nxt.freq_drain  = at(profile_regs_pkg::IDX_FREQ_DRAIN);
	end

	// ----------------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------------
	// One register stage keeps the wide assembly muxes off the loop's paths,
	// at the price of one cycle before a write is seen downstream.
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cfg_r <= '0;
		else
			cfg_r <= cfg_nxt;
	end

	// The loop consumes these settings only while this profile's reference is in use.
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			apply_r <= 1'b0;
		else
			apply_r <= profile_in_use_in;
	end

	assign loop_cfg_out  = cfg_r;
	assign cfg_apply_out = apply_r;

	// ----------------------------------------------------------------
	// Derived ratios
	// ----------------------------------------------------------------
	loop_ratio_unit u_ratio
	(
		.sys_clk_in        (sys_clk_in),
		.rstn_in           (rstn_in),
		.cfg_in            (cfg_r),
		.phase_scale_ns_in (phase_scale_ns_in),
		.in_div_ratio_out  (in_div_ratio_out),
		.fb_div_ratio_out  (fb_div_ratio_out),
		.fb_div_low_out    (fb_div_low_out),
		.phase_thr_ps_out  (phase_thr_ps_out)
	);

endmodule : dpll_reference_profile_one_regs
`default_nettype wire

/* profile_regs_sva.sv */
// Checker with the port-level assertions of the reference profile bank.
`timescale 1ns/100ps
`default_nettype none
module profile_regs_sva
(
	input  wire logic                        sys_clk_in,
	input  wire logic                        rstn_in,
	input  wire profile_regs_pkg::wb_req_t   wb_req_in,
	input  wire profile_regs_pkg::wb_rsp_t   wb_rsp_out,
	input  wire logic                        phase_scale_ns_in,
	input  wire logic                        profile_in_use_in,
	input  wire profile_regs_pkg::loop_cfg_t loop_cfg_out,
	input  wire logic                        cfg_apply_out,
	input  wire logic [30:0]                 in_div_ratio_out,
	input  wire logic [20:0]                 fb_div_ratio_out,
	input  wire logic                        fb_div_low_out,
	input  wire logic [25:0]                 phase_thr_ps_out
);
	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	// A taken request is answered on the very next edge, always.
	a_ack_latency: assert property (wb_req_in.cyc && wb_req_in.stb && !wb_rsp_out.ack |=> wb_rsp_out.ack)
		else $error("ack missing one cycle after request");
	a_ack_single: assert property (wb_rsp_out.ack |=> !wb_rsp_out.ack)
		else $error("ack longer than one cycle");
	a_ack_has_cause: assert property ($rose(wb_rsp_out.ack) |-> $past(wb_req_in.cyc && wb_req_in.stb))
		else $error("ack without request");
	a_rdata_upper_zero: assert property (wb_rsp_out.ack |-> wb_rsp_out.dat[31:8] == 24'h0)
		else $error("read data upper bits not zero");

	// ----------------------------------------------------------------
	// Derived outputs; the reset edge is skipped since $past sees reset values.
	// ----------------------------------------------------------------
	a_in_div_plus: assert property ($past(rstn_in) |->
		in_div_ratio_out == {1'b0, $past(loop_cfg_out.in_div)} + 31'h1)
		else $error("input divide ratio wrong");
	a_fb_div_plus: assert property ($past(rstn_in) |->
		fb_div_ratio_out == {1'b0, $past(loop_cfg_out.fb_div)} + 21'h1
		&& fb_div_low_out == ($past(loop_cfg_out.fb_div) < 20'h7))
		else $error("feedback ratio or low flag wrong");
	a_phase_units: assert property ($past(rstn_in) |-> phase_thr_ps_out ==
		{10'h0, $past(loop_cfg_out.phase_thr)} * ($past(phase_scale_ns_in) ? 26'h3E8 : 26'h1))
		else $error("phase threshold scaling wrong");
	a_apply_follows: assert property ($past(rstn_in) |-> cfg_apply_out == $past(profile_in_use_in))
		else $error("apply does not follow profile use");
	// The byte lands at the ack edge and the settings register one edge later,
	// so a change is only legal two edges after an acknowledged write.
	a_cfg_quiet: assert property ($past(rstn_in) && !$past(wb_rsp_out.ack && wb_req_in.we, 2)
		|-> $stable(loop_cfg_out))
		else $error("settings changed without a write");
endmodule : profile_regs_sva

bind dpll_reference_profile_one_regs profile_regs_sva chk_u (
	.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_req_in(wb_req_in), .wb_rsp_out(wb_rsp_out),
	.phase_scale_ns_in(phase_scale_ns_in), .profile_in_use_in(profile_in_use_in),
	.loop_cfg_out(loop_cfg_out), .cfg_apply_out(cfg_apply_out),
	.in_div_ratio_out(in_div_ratio_out), .fb_div_ratio_out(fb_div_ratio_out),
	.fb_div_low_out(fb_div_low_out), .phase_thr_ps_out(phase_thr_ps_out));
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the reference profile register bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ----------------------------------------------------------------
	// Signals and scoreboard
	// ----------------------------------------------------------------
	logic                        sys_clk_in;
	logic                        rstn_in;
	logic                        scale;
	logic                        in_use;
	profile_regs_pkg::wb_req_t   req;
	profile_regs_pkg::wb_rsp_t   rsp;
	profile_regs_pkg::loop_cfg_t cfg;
	logic                        apply;
	logic [30:0]                 in_ratio;
	logic [20:0]                 fb_ratio;
	logic                        fb_low;
	logic [25:0]                 thr_ps;
	logic [7:0]                  m [0:76];
	logic [7:0]                  expq [$];
	logic [19:0]                 fbv [3] = '{20'h00008, 20'h00007, 20'hFFFFF};
	int                          fail_count;
	int                          n_tests;

	dpll_reference_profile_one_regs dut_u (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_req_in(req), .wb_rsp_out(rsp),
		.phase_scale_ns_in(scale), .profile_in_use_in(in_use), .loop_cfg_out(cfg),
		.cfg_apply_out(apply), .in_div_ratio_out(in_ratio), .fb_div_ratio_out(fb_ratio),
		.fb_div_low_out(fb_low), .phase_thr_ps_out(thr_ps));

	// 125 MHz clock.
	initial
	begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [511:0] seen, input logic [511:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("mismatches=%0d comparisons=%0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// Stored bits per byte, indexed from the bank's first byte.
	function automatic logic [7:0] wmask(input int k);
		case (k)
			5, 6, 36:   return 8'h00;
			9, 12, 35:  return 8'h0F;
			22:         return 8'h7F;
			25, 32, 39: return 8'h3F;
			38:         return 8'hF3;
			default:    return (k >= 49) ? 8'h00 : 8'hFF;
		endcase
	endfunction : wmask

	// Assembled settings worked out from the byte model.
	function automatic profile_regs_pkg::loop_cfg_t exp_cfg();
		return {m[4], m[3], m[2], m[1], m[0], m[9][3:0], m[8], m[7], m[12][3:0], m[11], m[10],
			m[14], m[13], m[16], m[15], m[18], m[17], m[19][5:0], m[20][0], m[19][7:6],
			m[28][7:4], m[22][1:0], m[21], m[20][7:1], m[22][6:2], m[25][0], m[24], m[23],
			m[25][5:1], m[27][6:0], m[26], m[28][3:0], m[27][7], m[32][5:0], m[31], m[30],
			m[29], m[35][3:0], m[34], m[33], m[38][1:0], m[37], m[39][5:0], m[38][7:4],
			m[41], m[40], m[42], m[43], m[46], m[45], m[44], m[47], m[48]};
	endfunction : exp_cfg

	// One classic cycle; k is the byte offset from the bank's first index.
	task automatic wb_io(input logic we, input int k, input logic [7:0] d);
		int n;
		n = 0;
		if (!we)
			expq.push_back((k >= 0 && k <= 76) ? m[k] : 8'h00);
		else if (k >= 0 && k <= 76)
			m[k] = d & wmask(k);
		@(posedge sys_clk_in);
		req <= '{1'b1, 1'b1, we, 16'((k + 32'h633) * 4), 4'h1, {24'h0, d}};
		do
		begin
			@(posedge sys_clk_in);
			n++;
		end
		while (rsp.ack !== 1'b1);
		check(32'(n), 32'h2);
		req <= '0;
	endtask : wb_io

	// Covers the bank plus one unmapped byte on each side. The period pads get zeros, and the
	// feedback low byte never lets the programmed value drop below seven.
	task automatic sweep(input logic we);
		logic [7:0] d;
		for (int k = -1; k <= 77; k++)
		begin
			d = 8'($urandom);
			if (k == 5 || k == 6)
				d = 8'h00;
			else if (k == 33)
				d = d | 8'h08;
			wb_io(we, k, d);
		end
	endtask : sweep

	task automatic settle;
		repeat (2) @(posedge sys_clk_in);
		#1;
	endtask : settle

	// Read results are matched against the oldest expectation.
	always @(posedge sys_clk_in)
		if (rsp.ack === 1'b1 && req.we === 1'b0)
			check(rsp.dat, (expq.size() > 0) ? {24'h0, expq.pop_front()} : 32'hFFFFFFFF);

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h2661));
		req = '0;
		scale = 1'b0;
		in_use = 1'b0;
		rstn_in = 1'b0;
		fail_count = 0;
		n_tests = 0;
		foreach (m[k]) m[k] = 8'h00;
		repeat (5) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		@(posedge sys_clk_in);
		#1;
		check({in_ratio, fb_ratio, fb_low, thr_ps, apply}, {31'h1, 21'h1, 1'b1, 26'h0, 1'b0});
		sweep(1'b0);
		sweep(1'b1);
		sweep(1'b0);
		settle;
		check(cfg, exp_cfg());
		// Feedback values just above and at the minimum, then the largest.
		foreach (fbv[j])
		begin
			wb_io(1'b1, 33, fbv[j][7:0]);
			wb_io(1'b1, 34, fbv[j][15:8]);
			wb_io(1'b1, 35, {4'h0, fbv[j][19:16]});
			settle;
			check({fb_ratio, fb_low}, {21'(fbv[j]) + 21'h1, fbv[j] < 20'h7});
		end
		for (int k = 29; k <= 32; k++)
			wb_io(1'b1, k, 8'hFF);
		settle;
		check(in_ratio, 31'h40000000);
		for (int s = 0; s < 2; s++)
		begin
			@(posedge sys_clk_in);
			scale <= s[0];
			wb_io(1'b1, 41, 8'($urandom));
			settle;
			check(thr_ps, {10'h0, m[41], m[40]} * (s[0] ? 26'h3E8 : 26'h1));
		end
		for (int s = 1; s >= 0; s--)
		begin
			@(posedge sys_clk_in);
			in_use <= s[0];
			settle;
			check(apply, s[0]);
		end
		check(cfg, exp_cfg());
		// A second reset in mid-run clears every byte again.
		@(posedge sys_clk_in);
		rstn_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		foreach (m[k]) m[k] = 8'h00;
		sweep(1'b0);
		finish_test;
	end

	// About 1030 cycles are needed; 20000 cycles means a hang.
	initial
	begin
		#160000;
		fail_count++;
		finish_test;
	end
endmodule : testbench
`default_nettype wire
